// [rtl/ecd_pkg.sv]
// Shared constants and carrier types for the asymmetric command dispatcher
package ecd_pkg;

	// ==========================================================
	// Opcodes and key-agreement modes
	localparam logic [7:0] OP_AGREE = 8'h43;
	localparam logic [7:0] OP_KEYGEN = 8'h40;
	localparam logic [7:0] OP_SIGN = 8'h41;
	localparam logic [7:0] OP_VERIFY = 8'h45;
	localparam logic [7:0] MD_SLOT_CLEAR = 8'h0C;
	localparam logic [7:0] MD_SLOT_ENC = 8'h0E;
	localparam logic [7:0] MD_SLOT_KEEP = 8'h08;
	localparam logic [7:0] MD_SCR_CLEAR = 8'h0D;
	localparam logic [7:0] MD_SCR_ENC = 8'h0F;
	localparam logic [7:0] MD_SCR_KEEP = 8'h09;
	localparam logic [7:0] MD_SCR_SLOT = 8'h05;

	// ==========================================================
	// Key selector forms and slot set
	localparam int SLOT_W = 4;
	localparam logic [15:0] SEL_SCRATCH = 16'h0000;
	localparam logic [15:0] SEL_KEYGEN_SCRATCH = 16'hFFFF;
	localparam logic [11:0] SEL_SLOT_HI = 12'h000;
	localparam logic [15:0] AGREE_SLOT_MASK_DEF = 16'h001D;

	// ==========================================================
	// Status codes and response lengths
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] ERR_PARSE = 8'h03;
	localparam logic [7:0] ERR_POLICY = 8'h05;
	localparam logic [7:0] ERR_NO_SCRATCH = 8'h0F;
	localparam logic [6:0] LEN_ENGINE = 7'h00;
	localparam logic [6:0] LEN_STATUS = 7'h01;
	localparam logic [6:0] LEN_SECRET = 7'h20;
	localparam logic [6:0] LEN_SECRET_NONCE = 7'h40;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		DST_OUTBUF = 2'b00,
		DST_SCRATCH = 2'b01,
		DST_SLOT = 2'b10
	} ecd_dest_t;

	typedef enum logic [2:0] {
		ENG_AGREE = 3'b000,
		ENG_KEYGEN = 3'b001,
		ENG_SIGN = 3'b010,
		ENG_VERIFY = 3'b011,
		ENG_NONE = 3'b111
	} ecd_eop_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] mode;
		logic [15:0] key_selector;
	} ecd_cmd_t;

	typedef struct packed {
		logic priv_key;
		logic agree_ok;
		logic ecc_key;
	} ecd_policy_t;

	typedef struct packed {
		ecd_eop_t op;
		logic [7:0] mode;
		logic scratch_src;
		ecd_dest_t dest;
		logic [SLOT_W-1:0] slot;
		logic encrypt;
		logic io_protect_key;
	} ecd_eng_req_t;

	typedef struct packed {
		logic [7:0] status;
		logic [6:0] len;
		logic with_nonce;
		logic encrypted;
	} ecd_resp_t;

	typedef struct packed {
		ecd_eop_t op;
		logic bad;
		logic scratch_src;
		ecd_dest_t dest;
		logic need_policy;
		logic encrypt;
		logic [SLOT_W-1:0] slot;
		logic [6:0] ok_len;
	} ecd_dec_t;

endpackage : ecd_pkg

// [rtl/ecd_decode.sv]
// Opcode and mode decoder for the asymmetric command group
`timescale 1ns/1ps
`default_nettype none

module ecd_decode (
	// Command and option
	input wire ecd_pkg::ecd_cmd_t cmd_i,
	input wire logic protect_i,
	// Decoded route
	output ecd_pkg::ecd_dec_t dec_o
);
	import ecd_pkg::*;

	wire is_agree = (cmd_i.opcode == OP_AGREE);
	wire is_keygen = (cmd_i.opcode == OP_KEYGEN);
	wire is_sign = (cmd_i.opcode == OP_SIGN);
	wire is_verify = (cmd_i.opcode == OP_VERIFY);
	wire known = is_agree | is_keygen | is_sign | is_verify;
	wire sel_zero = (cmd_i.key_selector == SEL_SCRATCH);
	wire sel_slot = (cmd_i.key_selector[15:SLOT_W] == SEL_SLOT_HI);
	wire [7:0] md = cmd_i.mode;
	wire m_slot = (md == MD_SLOT_CLEAR) | (md == MD_SLOT_ENC) | (md == MD_SLOT_KEEP);
	wire m_scr = (md == MD_SCR_CLEAR) | (md == MD_SCR_ENC) | (md == MD_SCR_KEEP);
	wire m_scr_slot = (md == MD_SCR_SLOT);
	wire form_ok = (m_slot & sel_slot) | (m_scr & sel_zero) | (m_scr_slot & sel_slot);
	wire keep = (md == MD_SLOT_KEEP) | (md == MD_SCR_KEEP);
	wire enc_mode = (md == MD_SLOT_ENC) | (md == MD_SCR_ENC);
	ecd_dest_t dest;
	wire to_out;
	wire encrypt;

	// Only agreement results have a routing choice
	assign dest = !is_agree ? DST_OUTBUF : keep ? DST_SCRATCH
		: m_scr_slot ? DST_SLOT : DST_OUTBUF;
	assign to_out = (dest == DST_OUTBUF);
	// Protect option forces encryption, but never on internal results
	assign encrypt = is_agree & to_out & (enc_mode | protect_i);

	assign dec_o.op = is_agree ? ENG_AGREE : is_keygen ? ENG_KEYGEN
		: is_sign ? ENG_SIGN : is_verify ? ENG_VERIFY : ENG_NONE;
	assign dec_o.bad = !known | (is_agree & !form_ok);
	assign dec_o.scratch_src = is_agree & (m_scr | m_scr_slot);
	assign dec_o.dest = dest;
	assign dec_o.need_policy = (is_agree & m_slot)
		| (is_keygen & (cmd_i.key_selector != SEL_KEYGEN_SCRATCH));
	assign dec_o.encrypt = encrypt;
	assign dec_o.slot = cmd_i.key_selector[SLOT_W-1:0];
	assign dec_o.ok_len = !is_agree ? LEN_ENGINE : !to_out ? LEN_STATUS
		: encrypt ? LEN_SECRET_NONCE : LEN_SECRET;

endmodule : ecd_decode

`default_nettype wire

// [rtl/ecd_dispatch.sv]
// Command dispatch and execution control for the asymmetric command group
// Summary of operation
// - Opcode 0x43 selects key agreement
// - Opcode 0x40 selects key generation
// - Opcode 0x41 selects signing
// - Opcode 0x45 selects verification
// - Stored key needs private-key and agreement policy
// - Encrypted results use the I/O protection key
// - Only output-buffer results are ever encrypted
// - Stored-key agreement only slots 0, 2-4
// - Mode 0x0C returns 32 clear bytes
// - Mode 0x0E returns encrypted secret plus nonce
// - Mode 0x08 keeps secret, returns status
// - Failed output-buffer agreement returns one error byte
// - Protect option forces encryption in clear modes
// - Consuming scratch clears valid; writing back sets
// - Scratch modes 0x0D, 0x0F, 0x09 behave accordingly
// - Mode 0x05 stores secret into named slot
// - Modes 0x05, 0x09 return one status byte
// - Key generation rejects non-ECC slots
`timescale 1ns/1ps
`default_nettype none

module ecd_dispatch #(
	parameter logic [15:0] AGREE_SLOT_MASK = ecd_pkg::AGREE_SLOT_MASK_DEF
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Command packet from the framing block
	input wire logic cmd_valid_i,
	input wire ecd_pkg::ecd_cmd_t cmd_i,
	output logic cmd_ready_o,
	// Option bits
	input wire logic agreement_output_protect_i,
	// Slot access-policy lookup
	output logic pol_req_o,
	output logic [ecd_pkg::SLOT_W-1:0] pol_slot_o,
	input wire logic pol_valid_i,
	input wire ecd_pkg::ecd_policy_t pol_i,
	// Curve engine
	output logic eng_start_o,
	output ecd_pkg::ecd_eng_req_t eng_req_o,
	input wire logic eng_done_i,
	input wire logic eng_fail_i,
	input wire logic [7:0] eng_err_i,
	input wire logic [6:0] eng_len_i,
	// Response to the output buffer
	output logic resp_valid_o,
	output ecd_pkg::ecd_resp_t resp_o,
	// Scratch key buffer
	input wire logic scratch_loaded_i,
	output logic scratch_key_valid_flag_o
);
	import ecd_pkg::*;

	// ==========================================================
	// Elaboration check
	if (AGREE_SLOT_MASK == 16'h0000)
	begin : g_mask_check
		$error("ecd_dispatch: agreement slot mask is empty");
	end

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DECODE = 2'b01,
		ST_POLICY = 2'b10,
		ST_EXEC = 2'b11
	} ecd_state_t;

	ecd_state_t state_q;
	ecd_state_t state_d;
	ecd_cmd_t cmd_q;
	ecd_dec_t dec;
	logic flag_q;
	logic flag_d;
	ecd_eng_req_t eng_req_d;
	ecd_resp_t resp_d;

	ecd_decode u_decode (
		.cmd_i(cmd_q),
		.protect_i(agreement_output_protect_i),
		.dec_o(dec)
	);

	// ==========================================================
	// Decision terms
	wire cmd_take = cmd_valid_i & cmd_ready_o;
	wire in_decode = (state_q == ST_DECODE);
	wire in_policy = (state_q == ST_POLICY);
	wire in_exec = (state_q == ST_EXEC);
	wire stored_agree = (dec.op == ENG_AGREE) & !dec.scratch_src;
	wire bad_slot = stored_agree & !AGREE_SLOT_MASK[dec.slot];
	// Refuse a stale scratch key before the engine can touch it
	wire no_scratch = dec.scratch_src & !flag_q;
	wire [7:0] dec_code = dec.bad ? ERR_PARSE : bad_slot ? ERR_POLICY
		: no_scratch ? ERR_NO_SCRATCH : STATUS_OK;
	wire dec_err = (dec_code != STATUS_OK);
	wire pol_ok = (dec.op == ENG_AGREE) ? (pol_i.priv_key & pol_i.agree_ok)
		: pol_i.ecc_key;
	wire pol_done = in_policy & pol_valid_i;
	wire start_now = (in_decode & !dec_err & !dec.need_policy) | (pol_done & pol_ok);
	wire pol_req_now = in_decode & !dec_err & dec.need_policy;
	wire fail_now = (in_decode & dec_err) | (pol_done & !pol_ok);
	wire done_now = in_exec & eng_done_i;
	wire resp_now = fail_now | done_now;
	wire ok_done = done_now & !eng_fail_i;
	wire [7:0] fail_code = in_decode ? dec_code : ERR_POLICY;

	assign state_d = cmd_take ? ST_DECODE
		: pol_req_now ? ST_POLICY
		: start_now ? ST_EXEC
		: resp_now ? ST_IDLE
		: state_q;

	// ==========================================================
	// Engine request and response build
	assign eng_req_d.op = dec.op;
	assign eng_req_d.mode = cmd_q.mode;
	assign eng_req_d.scratch_src = dec.scratch_src;
	assign eng_req_d.dest = dec.dest;
	assign eng_req_d.slot = dec.slot;
	assign eng_req_d.encrypt = dec.encrypt;
	assign eng_req_d.io_protect_key = dec.encrypt;

	// Any failure answers with a single error byte, never a partial secret
	assign resp_d.status = fail_now ? fail_code : eng_fail_i ? eng_err_i : STATUS_OK;
	assign resp_d.len = (fail_now | eng_fail_i) ? LEN_STATUS
		: (dec.ok_len == LEN_ENGINE) ? eng_len_i : dec.ok_len;
	assign resp_d.with_nonce = ok_done & dec.encrypt;
	assign resp_d.encrypted = ok_done & dec.encrypt;

	// Scratch validity: a load wins over a same-cycle consumption
	wire flag_set = scratch_loaded_i
		| (ok_done & (dec.op == ENG_AGREE) & (dec.dest == DST_SCRATCH));
	wire flag_clr = start_now & dec.scratch_src;
	assign flag_d = flag_set ? 1'b1 : flag_clr ? 1'b0 : flag_q;

	// ==========================================================
	// Registers
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
			cmd_q <= '0;
			flag_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			flag_q <= flag_d;
			if (cmd_take)
				cmd_q <= cmd_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cmd_ready_o <= 1'b1;
			pol_req_o <= 1'b0;
			pol_slot_o <= '0;
			eng_start_o <= 1'b0;
			eng_req_o <= '0;
			resp_valid_o <= 1'b0;
			resp_o <= '0;
		end
		else
		begin
			cmd_ready_o <= (state_d == ST_IDLE);
			pol_req_o <= pol_req_now;
			eng_start_o <= start_now;
			resp_valid_o <= resp_now;
			if (pol_req_now)
				pol_slot_o <= dec.slot;
			if (start_now)
				eng_req_o <= eng_req_d;
			if (resp_now)
				resp_o <= resp_d;
		end
	end

	assign scratch_key_valid_flag_o = flag_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_bad_cmd_err:
	assert property (in_decode && dec.bad |=> resp_valid_o && !eng_start_o
		&& resp_o.status == ERR_PARSE && resp_o.len == LEN_STATUS)
		else $error("bad command did not answer with one parse error byte");

	a_slot_set:
	assert property (eng_start_o && eng_req_o.op == ENG_AGREE && !eng_req_o.scratch_src
		|-> AGREE_SLOT_MASK[eng_req_o.slot])
		else $error("stored-key agreement started on a forbidden slot");

	a_bad_slot_err:
	assert property (in_decode && !dec.bad && bad_slot |=> resp_valid_o
		&& !eng_start_o && resp_o.status == ERR_POLICY)
		else $error("forbidden slot not refused");

	a_policy_agree:
	assert property (pol_done && dec.op == ENG_AGREE && !(pol_i.priv_key && pol_i.agree_ok)
		|=> resp_valid_o && !eng_start_o ##1 !eng_start_o)
		else $error("agreement ran without private-key policy");

	a_policy_keygen:
	assert property (pol_done && dec.op == ENG_KEYGEN && !pol_i.ecc_key
		|=> resp_valid_o && resp_o.status != STATUS_OK && !eng_start_o)
		else $error("key generation ran on a non-ECC slot");

	a_enc_outbuf:
	assert property (eng_start_o && eng_req_o.dest != DST_OUTBUF |-> !eng_req_o.encrypt)
		else $error("internal result marked for encryption");

	a_enc_iokey:
	assert property (eng_start_o && eng_req_o.encrypt |-> eng_req_o.io_protect_key)
		else $error("encryption without the I/O protection key");

	a_clear_len:
	assert property (resp_valid_o && resp_o.status == STATUS_OK && cmd_q.opcode == OP_AGREE
		&& cmd_q.mode == MD_SLOT_CLEAR && !agreement_output_protect_i
		|-> resp_o.len == LEN_SECRET && !resp_o.encrypted)
		else $error("clear stored-key mode length wrong");

	a_enc_len:
	assert property (resp_valid_o && resp_o.status == STATUS_OK && cmd_q.opcode == OP_AGREE
		&& cmd_q.mode == MD_SLOT_ENC |-> resp_o.len == LEN_SECRET_NONCE && resp_o.with_nonce)
		else $error("encrypted mode must return secret and nonce");

	a_status_only:
	assert property (resp_valid_o && cmd_q.opcode == OP_AGREE && (cmd_q.mode == MD_SCR_SLOT
		|| cmd_q.mode == MD_SCR_KEEP || cmd_q.mode == MD_SLOT_KEEP) |-> resp_o.len == LEN_STATUS)
		else $error("internal-result mode returned more than a status byte");

	a_fail_byte:
	assert property (done_now && eng_fail_i |=> resp_valid_o && resp_o.len == LEN_STATUS
		&& resp_o.status == $past(eng_err_i) && !resp_o.with_nonce)
		else $error("engine failure not returned as one error byte");

	a_flag_clear:
	assert property (start_now && dec.scratch_src && !scratch_loaded_i
		|=> !scratch_key_valid_flag_o throughout eng_start_o [*1])
		else $error("scratch valid flag not cleared on consumption");

	a_flag_back:
	assert property (ok_done && dec.op == ENG_AGREE && dec.dest == DST_SCRATCH
		|=> scratch_key_valid_flag_o)
		else $error("scratch valid flag not set after write-back");

	a_stale_scratch:
	assert property (eng_start_o && eng_req_o.scratch_src |-> $past(flag_q, 1))
		else $error("agreement consumed an invalid scratch key");

	a_agree_route:
	assert property (eng_start_o && cmd_q.opcode == OP_AGREE |-> eng_req_o.op == ENG_AGREE)
		else $error("agreement opcode not routed to the agreement engine");

	a_keygen_route:
	assert property (eng_start_o && cmd_q.opcode == OP_KEYGEN |-> eng_req_o.op == ENG_KEYGEN)
		else $error("key generation opcode misrouted");

	a_sign_route:
	assert property (eng_start_o && cmd_q.opcode == OP_SIGN |-> eng_req_o.op == ENG_SIGN)
		else $error("signing opcode misrouted");

	a_verify_route:
	assert property (eng_start_o && cmd_q.opcode == OP_VERIFY |-> eng_req_o.op == ENG_VERIFY)
		else $error("verification opcode misrouted");

	a_refuse_untouched:
	assert property (fail_now && !scratch_loaded_i |=> !eng_start_o
		&& scratch_key_valid_flag_o == $past(flag_q))
		else $error("refused command touched the engine or the scratch flag");

	a_protect_force:
	assert property (resp_valid_o && resp_o.status == STATUS_OK && cmd_q.opcode == OP_AGREE
		&& (cmd_q.mode == MD_SLOT_CLEAR || cmd_q.mode == MD_SCR_CLEAR)
		&& agreement_output_protect_i |-> resp_o.encrypted && resp_o.len == LEN_SECRET_NONCE)
		else $error("protect option did not force encryption");

	a_keep_status:
	assert property (resp_valid_o && cmd_q.opcode == OP_AGREE && cmd_q.mode == MD_SLOT_KEEP
		|-> resp_o.len == LEN_STATUS && !resp_o.encrypted && !resp_o.with_nonce)
		else $error("stored-key keep mode returned more than a status byte");

	a_scr_enc_len:
	assert property (resp_valid_o && resp_o.status == STATUS_OK && cmd_q.opcode == OP_AGREE
		&& cmd_q.mode == MD_SCR_ENC |-> resp_o.encrypted && resp_o.len == LEN_SECRET_NONCE)
		else $error("scratch encrypted mode must return secret and nonce");

	a_slot_dest:
	assert property (eng_start_o && cmd_q.opcode == OP_AGREE && cmd_q.mode == MD_SCR_SLOT
		|-> eng_req_o.scratch_src && eng_req_o.dest == DST_SLOT && !eng_req_o.encrypt)
		else $error("scratch-to-slot mode not routed from scratch into a slot");

	c_slot_enc: cover property (resp_valid_o && resp_o.with_nonce);
	c_scr_keep: cover property (ok_done && dec.dest == DST_SCRATCH);
	c_scr_slot: cover property (ok_done && dec.dest == DST_SLOT);
	c_keygen_bad: cover property (pol_done && dec.op == ENG_KEYGEN && !pol_ok);
	c_protect_clear: cover property (resp_valid_o && resp_o.encrypted && cmd_q.mode == MD_SLOT_CLEAR);

endmodule : ecd_dispatch

`default_nettype wire

// [tb/ecd_far_model.sv]
// Far-side model: slot policy lookup and curve engine responder
`timescale 1ns/1ps
`default_nettype none

module ecd_far_model #(
	parameter logic [7:0] FAIL_CODE = 8'h07,
	parameter logic [6:0] ENG_LEN = 7'h40
) (
	// Clock and test knobs
	input wire logic mclk_i,
	input wire logic [1:0] dly_i,
	input wire logic deny_i,
	input wire logic fail_i,
	// Policy lookup
	input wire logic pol_req_i,
	input wire logic [ecd_pkg::SLOT_W-1:0] pol_slot_i,
	output logic pol_valid_o,
	output ecd_pkg::ecd_policy_t pol_o,
	// Curve engine
	input wire logic eng_start_i,
	output logic eng_done_o,
	output logic eng_fail_o,
	output logic [7:0] eng_err_o,
	output logic [6:0] eng_len_o
);
	import ecd_pkg::*;

	initial
	begin
		pol_valid_o = 1'b0;
		pol_o = '0;
		eng_done_o = 1'b0;
		eng_fail_o = 1'b0;
		eng_err_o = 8'h00;
		eng_len_o = 7'h00;
	end

	// ==========================================================
	// Policy: slots below 5 hold private keys, 12 and up are not ECC
	always
	begin
		@(negedge mclk_i);
		if (pol_req_i === 1'b1)
		begin
			repeat (dly_i) @(negedge mclk_i);
			pol_valid_o = 1'b1;
			pol_o = {pol_slot_i < 4'h5, !deny_i, pol_slot_i < 4'hC};
			@(negedge mclk_i);
			pol_valid_o = 1'b0;
			// Stale answer is inverted so a late sample cannot look valid
			pol_o = ~pol_o;
		end
	end

	// ==========================================================
	// Engine
	always
	begin
		@(negedge mclk_i);
		if (eng_start_i === 1'b1)
		begin
			repeat (dly_i) @(negedge mclk_i);
			eng_done_o = 1'b1;
			eng_fail_o = fail_i;
			eng_err_o = FAIL_CODE;
			eng_len_o = ENG_LEN;
			@(negedge mclk_i);
			eng_done_o = 1'b0;
			eng_fail_o = !fail_i;
			eng_err_o = ~eng_err_o;
			eng_len_o = ~eng_len_o;
		end
	end

endmodule : ecd_far_model

`default_nettype wire

// [tb/ecd_dispatch_tb_top.sv]
// Self-checking testbench for the asymmetric command dispatcher
`timescale 1ns/1ps
`default_nettype none

module ecd_dispatch_tb_top;
	import ecd_pkg::*;

	localparam logic [7:0] FCODE = 8'h07;
	localparam logic [6:0] ELEN = 7'h40;
	typedef struct packed {ecd_resp_t r; logic f;} ecd_note_t;

	logic mclk, rst_b, cv, prot, pv, ed, ef, sl, rdy, pr, es, rv, flag, deny, fail, flag_m;
	logic [1:0] dly;
	logic [4:0] px;
	logic [3:0] ps;
	logic [7:0] ee;
	logic [6:0] el;
	ecd_cmd_t cmd;
	ecd_policy_t pol;
	ecd_eng_req_t er, ex;
	ecd_resp_t rs;
	ecd_note_t nt;
	ecd_note_t nq[$];
	ecd_eng_req_t eq[$];
	int err_total, checked;

	ecd_dispatch i_dut (.mclk_i(mclk), .rst_b_i(rst_b), .cmd_valid_i(cv), .cmd_i(cmd),
		.cmd_ready_o(rdy), .agreement_output_protect_i(prot), .pol_req_o(pr), .pol_slot_o(ps),
		.pol_valid_i(pv), .pol_i(pol), .eng_start_o(es), .eng_req_o(er), .eng_done_i(ed),
		.eng_fail_i(ef), .eng_err_i(ee), .eng_len_i(el), .resp_valid_o(rv), .resp_o(rs),
		.scratch_loaded_i(sl), .scratch_key_valid_flag_o(flag));

	ecd_far_model #(.FAIL_CODE(FCODE), .ENG_LEN(ELEN)) i_far (.mclk_i(mclk), .dly_i(dly),
		.deny_i(deny), .fail_i(fail), .pol_req_i(pr), .pol_slot_i(ps), .pol_valid_o(pv),
		.pol_o(pol), .eng_start_i(es), .eng_done_o(ed), .eng_fail_o(ef), .eng_err_o(ee),
		.eng_len_o(el));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ==========================================================
	// Checking and verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Reference: expected engine request, response and flag
	task automatic predict(input ecd_cmd_t c);
		logic sf;
		logic go;
		logic pn;
		ecd_eng_req_t e;
		ecd_note_t n;
		sf = c.key_selector[15:4] == SEL_SLOT_HI;
		go = 1'b0;
		pn = 1'b0;
		e = '0;
		e.mode = c.mode;
		e.slot = c.key_selector[3:0];
		n = '0;
		n.r.status = ERR_PARSE;
		n.r.len = LEN_STATUS;
		case (c.opcode)
			OP_AGREE:
			begin
				e.op = ENG_AGREE;
				case (c.mode)
					MD_SLOT_CLEAR, MD_SLOT_ENC, MD_SLOT_KEEP:
					begin
						if (sf) n.r.status = ERR_POLICY;
						pn = sf && AGREE_SLOT_MASK_DEF[c.key_selector[3:0]];
						go = pn && !deny;
					end
					MD_SCR_CLEAR, MD_SCR_ENC, MD_SCR_KEEP, MD_SCR_SLOT:
					begin
						e.scratch_src = 1'b1;
						if (c.mode == MD_SCR_SLOT ? sf : c.key_selector == SEL_SCRATCH)
						begin
							n.r.status = ERR_NO_SCRATCH;
							go = flag_m;
						end
					end
					default: ;
				endcase
				e.dest = (c.mode == MD_SLOT_KEEP || c.mode == MD_SCR_KEEP) ? DST_SCRATCH :
					(c.mode == MD_SCR_SLOT) ? DST_SLOT : DST_OUTBUF;
				e.encrypt = e.dest == DST_OUTBUF && (c.mode[1] || prot);
				e.io_protect_key = e.encrypt;
			end
			OP_KEYGEN:
			begin
				e.op = ENG_KEYGEN;
				// Any selector but the scratch form is looked up as a slot
				pn = c.key_selector != SEL_KEYGEN_SCRATCH;
				if (pn) n.r.status = ERR_POLICY;
				go = !pn || c.key_selector[3:0] < 4'hC;
			end
			OP_SIGN, OP_VERIFY:
			begin
				e.op = (c.opcode == OP_SIGN) ? ENG_SIGN : ENG_VERIFY;
				go = 1'b1;
			end
			default: ;
		endcase
		px = {pn, c.key_selector[3:0]};
		if (go)
		begin
			eq.push_back(e);
			if (e.scratch_src) flag_m = 1'b0;
			n.r.status = fail ? FCODE : STATUS_OK;
			if (!fail)
			begin
				n.r.len = (e.op != ENG_AGREE) ? ELEN : (e.dest != DST_OUTBUF) ? LEN_STATUS :
					e.encrypt ? LEN_SECRET_NONCE : LEN_SECRET;
				n.r.with_nonce = e.encrypt;
				n.r.encrypted = e.encrypt;
				if (e.dest == DST_SCRATCH) flag_m = 1'b1;
			end
		end
		n.f = flag_m;
		nq.push_back(n);
	endtask : predict

	// ==========================================================
	// Stimulus
	function automatic ecd_cmd_t rcmd();
		ecd_cmd_t c;
		logic [7:0] ops[6] = '{OP_AGREE, OP_AGREE, OP_AGREE, OP_KEYGEN, OP_SIGN, OP_VERIFY};
		logic [7:0] md[8] = '{MD_SLOT_CLEAR, MD_SLOT_ENC, MD_SLOT_KEEP, MD_SCR_CLEAR, MD_SCR_ENC,
			MD_SCR_KEEP, MD_SCR_SLOT, 8'h0A};
		c.opcode = ($urandom % 8 == 0) ? 8'($urandom) : ops[$urandom % 6];
		c.mode = (c.opcode == OP_AGREE) ? md[$urandom % 8] : 8'h00;
		c.key_selector = ($urandom % 3 == 0) ? SEL_SCRATCH : ($urandom % 4 == 0) ? 16'($urandom) :
			($urandom % 6 == 0) ? SEL_KEYGEN_SCRATCH : {SEL_SLOT_HI, 4'($urandom)};
		// Sign and verify selector checks are outside this block
		if (c.opcode == OP_SIGN || c.opcode == OP_VERIFY) c.key_selector[15:4] = SEL_SLOT_HI;
		return c;
	endfunction : rcmd

	task automatic send(input ecd_cmd_t c);
		cv = 1'b1;
		cmd = c;
		while (rdy !== 1'b1) @(negedge mclk);
		predict(c);
		@(negedge mclk);
	endtask : send

	// Knobs change only while nothing is in flight
	task automatic idle();
		cv = 1'b0;
		while (nq.size() != 0 || eq.size() != 0) @(negedge mclk);
		// The response cycle itself still reads the option live
		@(negedge mclk);
		prot = 1'($urandom);
		fail = ($urandom % 4 == 0);
		deny = ($urandom % 5 == 0);
		dly = 2'($urandom);
		if ($urandom % 2 == 1)
		begin
			sl = 1'b1;
			flag_m = 1'b1;
			@(negedge mclk);
			sl = 1'b0;
		end
	endtask : idle

	// ==========================================================
	// Output monitor
	always @(negedge mclk)
	begin
		if (rst_b === 1'b1 && es === 1'b1)
		begin
			chk({31'h0, eq.size() > 0}, 32'h1);
			ex = eq.size() > 0 ? eq.pop_front() : '0;
			chk({12'h0, er}, {12'h0, ex});
		end
		if (rst_b === 1'b1 && pr === 1'b1)
			chk({27'h0, 1'b1, ps}, {27'h0, px});
		if (rst_b === 1'b1 && rv === 1'b1)
		begin
			chk({31'h0, nq.size() > 0}, 32'h1);
			nt = nq.size() > 0 ? nq.pop_front() : '0;
			chk({14'h0, rs, flag}, {14'h0, nt});
		end
	end

	initial
	begin
		#200000;
		err_total++;
		complete_run();
	end

	initial
	begin
		{rst_b, cv, prot, sl, deny, fail, flag_m} = '0;
		cmd = '0;
		dly = 2'h0;
		err_total = 0;
		checked = 0;
		void'($urandom(32'h5cfe5a17));
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
		chk({30'h0, rdy, flag}, 32'h2);
		for (int i = 0; i < 400; i++)
		begin
			if ($urandom % 4 != 0) idle();
			send(rcmd());
		end
		idle();
		complete_run();
	end

endmodule : ecd_dispatch_tb_top

`default_nettype wire
